/* File: rtl/timer_irq_mask_flag_logic.sv */
// interrupt enable and flag logic for the two 16-bit timers, apb slave
// assumes timer events arrive on CLK; fuse level comes from outside
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "timer_irq_map.svh"

module timer_irq_mask_flag_logic (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic LEGACY_MODE_FUSE,
  input wire timer_irq_pkg::timer_evt_t T1_EVT,
  input wire timer_irq_pkg::timer_evt_t T3_EVT,
  input wire logic [9:0] VECTOR_ACK,
  output logic [9:0] IRQ_REQ
);
  import timer_irq_pkg::*;

  logic [9:0] flag_reg;
  logic [9:0] flag_next;
  logic [9:0] en_reg;
  logic [9:0] en_next;
  logic [31:0] prdata_reg;
  logic legacy_meta_reg;
  logic legacy_reg;
  logic [2:0] pend_reg [2];
  timer_evt_t evt [2];
  timer_bits_t set_t [2];

  assign evt[0] = T1_EVT;
  assign evt[1] = T3_EVT;

  // fuse is a foreign level; first flop feeds only the second
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      legacy_meta_reg <= 1'b0;
      legacy_reg <= 1'b0;
    end else if (CE) begin
      legacy_meta_reg <= LEGACY_MODE_FUSE;
      legacy_reg <= legacy_meta_reg;
    end
  end

  // per timer event qualification
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      wire [2:0] cmp_hit = evt[gi].cmp_equal & ~evt[gi].force_cmp_strobe;
      wire plain_ovf_mode = (evt[gi].waveform_generation_select == `WGM_NORMAL) ||
                            (evt[gi].waveform_generation_select == `WGM_CTC_OCR) ||
                            (evt[gi].waveform_generation_select == `WGM_CTC_ICR);
      wire cap_set = evt[gi].icr_is_top ? evt[gi].top_reached
                                        : evt[gi].capture_pin_evt;
      wire ovf_set = plain_ovf_mode ? evt[gi].overflow : evt[gi].wave_ovf_point;
      wire [2:0] cmp_set = evt[gi].tick ? pend_reg[gi] : 3'h0;

      // match is held until the next timer tick, then it becomes a flag
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          pend_reg[gi] <= 3'h0;
        end else if (CE && evt[gi].tick) begin
          pend_reg[gi] <= cmp_hit;
        end
      end

      assign set_t[gi] = {cap_set, cmp_set[0], cmp_set[1], ovf_set, cmp_set[2]};
    end
  endgenerate

  // apb decode
  wire setup_ph = CE && PSEL && !PENABLE;
  wire access_ph = CE && PSEL && PENABLE;
  wire [7:0] word_idx = PADDR[9:2];
  wire hit_timer_event_flags = (word_idx == `TIMER_EVENT_FLAGS_IDX);
  wire hit_timsk = (word_idx == `TIMER_IRQ_ENABLES_IDX);
  wire hit_extended_timer_event_flags = (word_idx == `EXT_TIMER_EVENT_FLAGS_IDX);
  wire hit_extended_timer_irq_enables = (word_idx == `EXT_TIMER_IRQ_ENABLES_IDX) && !legacy_reg;
  wire hit_any = hit_timer_event_flags || hit_timsk || hit_extended_timer_event_flags || hit_extended_timer_irq_enables;
  wire wr_en = access_ph && PWRITE;

  // register images; unused and reserved bits read zero
  wire [7:0] timer_event_flags_img = {2'h0, flag_reg[4:1], 2'h0};
  wire [7:0] timsk_img = {2'h0, en_reg[4:1], 2'h0};
  wire [7:0] extended_timer_event_flags_img = {2'h0, flag_reg[9:5], flag_reg[0]};
  wire [7:0] extended_timer_irq_enables_img = {2'h0, en_reg[9:5], en_reg[0]};
  wire [7:0] rd_byte = hit_timer_event_flags ? timer_event_flags_img :
                       hit_timsk ? timsk_img :
                       hit_extended_timer_event_flags ? extended_timer_event_flags_img :
                       hit_extended_timer_irq_enables ? extended_timer_irq_enables_img : 8'h00;

  // write-one-clear from bus, bits 7:6 of the flag words ignored
  wire [9:0] bus_clr = {(hit_extended_timer_event_flags && wr_en) ? PWDATA[5:1] : 5'h00,
                        (hit_timer_event_flags && wr_en) ? PWDATA[5:2] : 4'h0,
                        (hit_extended_timer_event_flags && wr_en) ? PWDATA[0] : 1'b0};
  wire [9:0] clr_v = bus_clr | VECTOR_ACK;
  wire [9:0] set_v = {set_t[1], set_t[0]};

  // set wins over a clear in the same cycle
  assign flag_next = (flag_reg & ~clr_v) | set_v;

  assign en_next[0] = (hit_extended_timer_irq_enables && wr_en) ? PWDATA[`EXT_T1_CMP_C_BIT] : en_reg[0];
  assign en_next[4:1] = (hit_timsk && wr_en) ? PWDATA[5:2] : en_reg[4:1];
  assign en_next[9:5] = (hit_extended_timer_irq_enables && wr_en) ? PWDATA[5:1] : en_reg[9:5];

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      flag_reg <= `FLAGS_RESET;
      en_reg <= `ENABLES_RESET;
      prdata_reg <= 32'h0000_0000;
    end else if (CE) begin
      flag_reg <= flag_next;
      en_reg <= en_next;
      if (setup_ph) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // legacy mode hides the extended enables from the request gate too
  wire [9:0] en_eff = legacy_reg ? {5'h00, en_reg[4:1], 1'b0} : en_reg;

  // level requests, no latch, drop as soon as any term drops
  assign IRQ_REQ = flag_reg & en_eff & {10{GLOBAL_IRQ_EN}};

  // read data is captured in setup, so the access phase waits only while CE is low
  assign PREADY = CE;
  assign PSLVERR = access_ph && !hit_any;
  assign PRDATA = prdata_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_t1_ovf_gate: assert property (IRQ_REQ[1] |-> GLOBAL_IRQ_EN && en_reg[1] && flag_reg[1])
    else $error("timer 1 overflow request without all three terms");

  a_legacy_hides: assert property (access_ph && legacy_reg &&
      word_idx == `EXT_TIMER_IRQ_ENABLES_IDX |-> PSLVERR)
    else $error("extended enable register visible in legacy mode");

  a_legacy_no_req: assert property (legacy_reg |-> IRQ_REQ[9:5] == 5'h00 && !IRQ_REQ[0])
    else $error("extended request raised in legacy mode");

  a_reserved_zero: assert property (setup_ph && hit_extended_timer_irq_enables |=> PRDATA[31:6] == 26'h0)
    else $error("reserved enable bits read nonzero");

  // global enable and fuse may move under a held flag, so the consequent allows for them
  a_t3_req_level: assert property (CE && flag_reg[9] && en_reg[9] && !legacy_reg &&
      GLOBAL_IRQ_EN && !clr_v[9] && !(wr_en && hit_extended_timer_irq_enables) |=>
      (!GLOBAL_IRQ_EN || legacy_reg || IRQ_REQ[9]))
    else $error("timer 3 capture request not held");

  a_cmp_next_tick: assert property (CE && T1_EVT.tick && T1_EVT.cmp_equal[0] &&
      !T1_EVT.force_cmp_strobe[0] ##1 (CE && T1_EVT.tick) |=> flag_reg[3])
    else $error("compare flag not set on the following tick");

  a_force_blocks: assert property (CE && T3_EVT.tick && T3_EVT.force_cmp_strobe[1] |=>
      !pend_reg[1][1])
    else $error("forced strobe armed a compare flag");

  a_ovf_normal: assert property (CE && T3_EVT.overflow &&
      T3_EVT.waveform_generation_select == `WGM_NORMAL |=> flag_reg[6])
    else $error("overflow in normal mode did not set the flag");

  a_w1c_clear: assert property (wr_en && hit_timer_event_flags && PWDATA[2] && !set_v[1] &&
      !VECTOR_ACK[1] |=> !flag_reg[1])
    else $error("write one did not clear the flag");

  a_w0_keeps: assert property (wr_en && hit_extended_timer_event_flags && !PWDATA[5] && flag_reg[9] &&
      !VECTOR_ACK[9] |=> flag_reg[9])
    else $error("write zero disturbed a flag");

  a_set_wins: assert property (CE && VECTOR_ACK[4] && set_v[4] |=> flag_reg[4])
    else $error("clear beat a simultaneous set");

  a_cap_top: assert property (CE && T1_EVT.icr_is_top && T1_EVT.top_reached |=> flag_reg[4])
    else $error("capture flag missed top in capture-top mode");

  a_req_drop: assert property (!GLOBAL_IRQ_EN |-> IRQ_REQ == 10'h000)
    else $error("request while globally disabled");

  a_t3_cap_gate: assert property (
      IRQ_REQ[9] |-> GLOBAL_IRQ_EN && en_reg[9] && flag_reg[9])
    else $error("timer 3 capture request without all three terms");

  a_t3_cmpa_gate: assert property (
      IRQ_REQ[8] |-> GLOBAL_IRQ_EN && en_reg[8] && flag_reg[8])
    else $error("timer 3 compare a request without all three terms");

  a_t3_cmpb_gate: assert property (
      IRQ_REQ[7] |-> GLOBAL_IRQ_EN && en_reg[7] && flag_reg[7])
    else $error("timer 3 compare b request without all three terms");

  a_t3_ovf_gate: assert property (
      IRQ_REQ[6] |-> GLOBAL_IRQ_EN && en_reg[6] && flag_reg[6])
    else $error("timer 3 overflow request without all three terms");

  a_t3_cmpc_gate: assert property (
      IRQ_REQ[5] |-> GLOBAL_IRQ_EN && en_reg[5] && flag_reg[5])
    else $error("timer 3 compare c request without all three terms");

  a_t1_cmpc_gate: assert property (
      IRQ_REQ[0] |-> GLOBAL_IRQ_EN && en_reg[0] && flag_reg[0])
    else $error("timer 1 compare c request without all three terms");

  a_t1_cap_gate: assert property (
      IRQ_REQ[4] |-> GLOBAL_IRQ_EN && en_reg[4] && flag_reg[4])
    else $error("timer 1 capture request without all three terms");

  a_t1_cmpa_gate: assert property (
      IRQ_REQ[3] |-> GLOBAL_IRQ_EN && en_reg[3] && flag_reg[3])
    else $error("timer 1 compare a request without all three terms");

  a_t1_cmpb_gate: assert property (
      IRQ_REQ[2] |-> GLOBAL_IRQ_EN && en_reg[2] && flag_reg[2])
    else $error("timer 1 compare b request without all three terms");

  a_req_full: assert property (
      GLOBAL_IRQ_EN && !legacy_reg |-> IRQ_REQ == (flag_reg & en_reg))
    else $error("request missing while flag and enables are set");

  a_legacy_req: assert property (
      legacy_reg && GLOBAL_IRQ_EN |-> IRQ_REQ[4:1] == (flag_reg[4:1] & en_reg[4:1]))
    else $error("base requests disturbed in legacy mode");

  a_ext_en_hold: assert property (
      access_ph && PWRITE && legacy_reg && word_idx == `EXT_TIMER_IRQ_ENABLES_IDX |=> en_reg == $past(en_reg))
    else $error("hidden extended enable register took a write");

  a_ext_en_write: assert property (
      wr_en && hit_extended_timer_irq_enables |=> en_reg[9:5] == $past(PWDATA[5:1]) && en_reg[0] == $past(PWDATA[0]))
    else $error("extended enable write did not land");

  a_t1_en_write: assert property (
      wr_en && hit_timsk |=> en_reg[4:1] == $past(PWDATA[5:2]))
    else $error("timer 1 enable write did not land");

  a_t3_cap_pin: assert property (
      CE && !T3_EVT.icr_is_top && T3_EVT.capture_pin_evt |=> flag_reg[9])
    else $error("timer 3 pin capture did not set the flag");

  a_t3_cap_top: assert property (
      CE && T3_EVT.icr_is_top && T3_EVT.top_reached |=> flag_reg[9])
    else $error("timer 3 capture flag missed top");

  a_t1_cap_pin: assert property (
      CE && !T1_EVT.icr_is_top && T1_EVT.capture_pin_evt |=> flag_reg[4])
    else $error("timer 1 pin capture did not set the flag");

  a_t3_cmp_tick: assert property (
      CE && T3_EVT.tick && T3_EVT.cmp_equal[2] && !T3_EVT.force_cmp_strobe[2] ##1 (CE && T3_EVT.tick) |=> flag_reg[5])
    else $error("timer 3 compare c flag not set on the following tick");

  a_t1_cmpc_tick: assert property (
      CE && T1_EVT.tick && T1_EVT.cmp_equal[2] && !T1_EVT.force_cmp_strobe[2] ##1 (CE && T1_EVT.tick) |=> flag_reg[0])
    else $error("timer 1 compare c flag not set on the following tick");

  a_force_t1: assert property (
      CE && T1_EVT.tick && T1_EVT.force_cmp_strobe[0] |=> !pend_reg[0][0])
    else $error("forced strobe armed a timer 1 compare flag");

  a_ovf_ctc: assert property (
      CE && T1_EVT.overflow && T1_EVT.waveform_generation_select == `WGM_CTC_OCR |=> flag_reg[1])
    else $error("overflow in clear on compare mode did not set the flag");

  a_wave_point: assert property (
      CE && T1_EVT.wave_ovf_point && T1_EVT.waveform_generation_select != `WGM_NORMAL &&
      T1_EVT.waveform_generation_select != `WGM_CTC_OCR && T1_EVT.waveform_generation_select != `WGM_CTC_ICR |=> flag_reg[1])
    else $error("waveform overflow point did not set the flag");

  a_no_stray_ovf: assert property (
      CE && !flag_reg[6] && !set_v[6] |=> !flag_reg[6])
    else $error("overflow flag rose without an event");

  a_vec_clear: assert property (
      CE && VECTOR_ACK[9] && !set_v[9] |=> !flag_reg[9])
    else $error("vector execution did not clear the flag");

  a_ext_w1c: assert property (
      wr_en && hit_extended_timer_event_flags && PWDATA[0] && !set_v[0] && !VECTOR_ACK[0] |=> !flag_reg[0])
    else $error("write one did not clear the extended flag");

  a_flag_hold: assert property (
      CE && flag_reg[4] && !clr_v[4] |=> flag_reg[4])
    else $error("flag dropped without a clear");

  a_flag_pos: assert property (
      setup_ph && hit_timer_event_flags |=> PRDATA[7:0] == {2'h0, $past(flag_reg[4:1]), 2'h0})
    else $error("timer 1 flags read at wrong positions");

  a_ext_flag_pos: assert property (
      setup_ph && hit_extended_timer_event_flags |=> PRDATA[7:0] == {2'h0, $past(flag_reg[9:5]), $past(flag_reg[0])})
    else $error("extended flags read at wrong positions");

  a_flag_mapped: assert property (
      access_ph && (hit_timer_event_flags || hit_extended_timer_event_flags) |-> !PSLVERR)
    else $error("flag register answered with an error");

  c_t1_ovf_irq: cover property (CE && T1_EVT.overflow ##1 IRQ_REQ[1]);
  c_t3_cmp_c: cover property (flag_reg[5] && en_reg[5] && GLOBAL_IRQ_EN);
  c_vec_clear: cover property (IRQ_REQ[9] ##1 VECTOR_ACK[9] ##1 !IRQ_REQ[9]);
  c_unmapped: cover property (PSLVERR && PREADY);
  c_legacy_block: cover property (legacy_reg && access_ph && word_idx == `EXT_TIMER_IRQ_ENABLES_IDX);

endmodule

/* File: shared/timer_irq_map.svh */
// register indices, field positions, reset values and mode codes
// assumes a 32-bit apb word per register, byte address = index * 4
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

`define TIMER_EVENT_FLAGS_IDX 8'h36
`define TIMER_IRQ_ENABLES_IDX 8'h37
`define EXT_TIMER_EVENT_FLAGS_IDX 8'h7c
`define EXT_TIMER_IRQ_ENABLES_IDX 8'h7d

`define FLAGS_RESET 10'h000
`define ENABLES_RESET 10'h000

// positions in the base registers (timer 1: capture, cmp a, cmp b, overflow)
`define BASE_FIELD_LSB 2
`define BASE_FIELD_MSB 5
// positions in the extended registers (timer 3 five bits, timer 1 cmp c)
`define EXT_T3_LSB 1
`define EXT_T3_MSB 5
`define EXT_T1_CMP_C_BIT 0

// waveform generation codes that give a plain overflow
`define WGM_NORMAL 4'h0
`define WGM_CTC_OCR 4'h4
`define WGM_CTC_ICR 4'hc

`endif

/* File: shared/timer_irq_pkg.sv */
// types shared by the timer interrupt mask and flag logic
// assumes the timer counter units run on the same clock
package timer_irq_pkg;

  // events from one 16-bit timer unit, all same-clock single-cycle pulses
  // except icr_is_top and waveform_generation_select, which are levels
  typedef struct packed {
    logic tick;
    logic capture_pin_evt;
    logic top_reached;
    logic icr_is_top;
    logic [2:0] cmp_equal;
    logic [2:0] force_cmp_strobe;
    logic overflow;
    logic wave_ovf_point;
    logic [3:0] waveform_generation_select;
  } timer_evt_t;

  // per timer flag or enable layout: capture, cmp a, cmp b, overflow, cmp c
  typedef logic [4:0] timer_bits_t;

endpackage

/* File: verification/timer_irq_mask_flag_logic_tb.sv */
// self-checking bench: apb register tasks and timer event pulses
// assumes the clock enable stays high and the timer ticks every cycle
`timescale 1ns/1ps
`include "timer_irq_map.svh"

module timer_irq_mask_flag_logic_tb;
  import timer_irq_pkg::*;
  localparam logic [9:0] A_FLG = {`TIMER_EVENT_FLAGS_IDX, 2'b00};
  localparam logic [9:0] A_EN = {`TIMER_IRQ_ENABLES_IDX, 2'b00};
  localparam logic [9:0] A_XFLG = {`EXT_TIMER_EVENT_FLAGS_IDX, 2'b00};
  localparam logic [9:0] A_XEN = {`EXT_TIMER_IRQ_ENABLES_IDX, 2'b00};
  localparam logic [3:0] MODES [3] = '{4'h4, 4'hc, 4'h1};
  logic CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [9:0] PADDR = '0, fire1 = '0, fire3 = '0, vack = '0;
  logic [31:0] PWDATA = '0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, glob = 1'b0, fuse = 1'b0, t1_capture_register = 1'b0, t3_capture_register = 1'b0;
  logic [3:0] mode1 = '0, mode3 = '0;
  logic [9:0] IRQ_REQ;
  logic [32:0] r;
  timer_evt_t t1_evt, t3_evt;
  int error_cnt = 0;
  int n_checks = 0;
  always #20 CLK = ~CLK;
  timer_irq_mask_flag_logic i_timer_irq_mask_flag_logic (.CLK(CLK), .RESET_N(RESET_N), .CE(1'b1),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .GLOBAL_IRQ_EN(glob), .LEGACY_MODE_FUSE(fuse),
    .T1_EVT(t1_evt), .T3_EVT(t3_evt), .VECTOR_ACK(vack), .IRQ_REQ(IRQ_REQ));
  timer_unit_model i_timer_unit_model (.FIRE(fire1), .MODE(mode1), .ICR_TOP(t1_capture_register), .EVT(t1_evt));
  timer_unit_model i_timer_unit_model_3 (.FIRE(fire3), .MODE(mode3), .ICR_TOP(t3_capture_register), .EVT(t3_evt));
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      end_sim();
    end
    r = {PSLVERR, PRDATA};
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, '0);
    chk({ee, e}, r);
  endtask
  task fire(input logic [9:0] f1, input logic [9:0] f3);
    @(posedge CLK);
    fire1 <= f1; fire3 <= f3;
    @(posedge CLK);
    fire1 <= '0; fire3 <= '0;
    repeat (2) @(posedge CLK);
  endtask
  // reserved bits written as zero on every clear
  task clr;
    apb(1'b1, A_FLG, 32'h3c);
    apb(1'b1, A_XFLG, 32'h3f);
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    rdc(A_FLG, 0, 0);
    rdc(A_EN, 0, 0);
    rdc(A_XFLG, 0, 0);
    rdc(A_XEN, 0, 0);
    $display("test reset done");
    apb(1'b1, A_EN, 32'h3c);
    apb(1'b1, A_XEN, 32'hff);
    rdc(A_XEN, 32'h3f, 0);
    glob <= 1'b1;
    fire(10'h075, 10'h075);
    chk(10'h3ff, IRQ_REQ);
    rdc(A_FLG, 32'h3c, 0);
    rdc(A_XFLG, 32'h3f, 0);
    @(posedge CLK) glob <= 1'b0;
    @(posedge CLK) #1 chk(0, IRQ_REQ);
    glob <= 1'b1;
    $display("test requests done");
    apb(1'b1, A_FLG, 32'h00);
    rdc(A_FLG, 32'h3c, 0);
    apb(1'b1, A_FLG, 32'h24);
    rdc(A_FLG, 32'h18, 0);
    @(posedge CLK) vack <= 10'h008;
    @(posedge CLK) vack <= '0;
    rdc(A_FLG, 32'h08, 0);
    chk(10'h3e5, IRQ_REQ);
    clr();
    fire(10'h3f0, 10'h3f0);
    rdc(A_FLG, 0, 0);
    rdc(A_XFLG, 0, 0);
    $display("test clear and force done");
    for (int k = 0; k < 3; k++) begin
      mode1 <= MODES[k];
      mode3 <= MODES[k];
      fire(10'h004, 10'h004);
      rdc(A_XFLG, (k == 2) ? 32'h0 : 32'h4, 0);
      clr();
      fire(10'h008, 10'h008);
      rdc(A_FLG, (k == 2) ? 32'h4 : 32'h0, 0);
      clr();
    end
    t1_capture_register <= 1'b1; t3_capture_register <= 1'b1;
    fire(10'h001, 10'h001);
    rdc(A_FLG, 0, 0);
    fire(10'h002, 10'h002);
    rdc(A_FLG, 32'h20, 0);
    rdc(A_XFLG, 32'h20, 0);
    clr();
    $display("test modes done");
    @(posedge CLK) fire1 <= 10'h010;
    @(posedge CLK) fire1 <= '0;
    #1 chk(0, IRQ_REQ[3]);
    @(posedge CLK) #1 chk(1, IRQ_REQ[3]);
    rdc(10'h004, 0, 1);
    fuse <= 1'b1;
    fire(10'h000, 10'h075);
    rdc(A_XEN, 0, 1);
    chk(10'h008, IRQ_REQ);
    $display("test legacy done");
    end_sim();
  end
endmodule

/* File: verification/timer_unit_model.sv */
// timer unit model: turns one-cycle command bits into timer event pulses
// assumes commands change just after a CLK edge and last one cycle
`timescale 1ns/1ps

module timer_unit_model (
  input wire logic [9:0] FIRE,
  input wire logic [3:0] MODE,
  input wire logic ICR_TOP,
  output timer_irq_pkg::timer_evt_t EVT
);
  import timer_irq_pkg::*;
  // fire: 0 pin capture, 1 top, 2 overflow, 3 wave point, 6:4 equal, 9:7 force
  // timer runs at the system rate, so every cycle is a tick
  assign EVT.tick = 1'b1;
  assign EVT.capture_pin_evt = FIRE[0];
  assign EVT.top_reached = FIRE[1];
  assign EVT.icr_is_top = ICR_TOP;
  assign EVT.cmp_equal = FIRE[6:4];
  assign EVT.force_cmp_strobe = FIRE[9:7];
  assign EVT.overflow = FIRE[2];
  assign EVT.wave_ovf_point = FIRE[3];
  assign EVT.waveform_generation_select = MODE;
endmodule
